// *** common/wrfs_defines.svh ***
// Timing constants, packet codes and field values of the receiver fault supervisor
`ifndef WRFS_DEFINES_SVH
`define WRFS_DEFINES_SVH

`define WRFS_CLK_HZ            25000000
`define WRFS_UV_TIME_MS        3500
`define WRFS_OCL_TIME_MS       4
`define WRFS_TSD_TIME_MS       200
`define WRFS_OTP_TIME_MS       1
`define WRFS_OV_TIME_MS        64
`define WRFS_UV_CYCLES         ((`WRFS_CLK_HZ / 1000) * `WRFS_UV_TIME_MS)
`define WRFS_OCL_CYCLES        ((`WRFS_CLK_HZ / 1000) * `WRFS_OCL_TIME_MS)
`define WRFS_TSD_CYCLES        ((`WRFS_CLK_HZ / 1000) * `WRFS_TSD_TIME_MS)
`define WRFS_OTP_CYCLES        ((`WRFS_CLK_HZ / 1000) * `WRFS_OTP_TIME_MS)
`define WRFS_OV_CYCLES         ((`WRFS_CLK_HZ / 1000) * `WRFS_OV_TIME_MS)
`define WRFS_RECTIFIED_VOLTAGE_CYCLES      32'd2500000

`define WRFS_HDR_CONFIG        8'h51
`define WRFS_HDR_CTRL_ERR      8'h03
`define WRFS_HDR_RX_POWER      8'h04
`define WRFS_HDR_EPT           8'h02
`define WRFS_CFG_MAX_POWER     6'h0a
`define WRFS_CFG_POWER_CLASS   2'h0
`define WRFS_CFG_PROP          2'h0
`define WRFS_CFG_COUNT         3'h0
`define WRFS_CFG_WIN_SIZE      5'h04
`define WRFS_CFG_WIN_OFFSET    3'h1

`define WRFS_EPT_UNKNOWN       8'h00
`define WRFS_EPT_COMPLETE      8'h01
`define WRFS_EPT_OVER_TEMP     8'h03
`define WRFS_EPT_OVER_CURRENT  8'h05
`define WRFS_EPT_BATTERY_FAIL  8'h06
`define WRFS_EPT_NO_RESPONSE   8'h08

`define WRFS_IOUT_SYNC_MA      12'h0fa
`define WRFS_IOUT_DIODE_MA     12'h0dc
`define WRFS_OCL_HIGH_MA       12'h514
`define WRFS_OCL_LOW_MA        12'h15e

`endif

// *** common/wrfs_pkg.sv ***
// Types shared by the receiver fault supervisor
package wrfs_pkg;

  typedef enum logic [1:0] {
    WRFS_RECT_BRIDGE = 2'b00,
    WRFS_RECT_DIODE  = 2'b01,
    WRFS_RECT_SYNC   = 2'b10
  } wrfs_rect_type;

  typedef enum logic [1:0] {
    WRFS_PH_SHUTDOWN = 2'b00,
    WRFS_PH_STARTUP  = 2'b01,
    WRFS_PH_OUTPUT   = 2'b10
  } wrfs_phase_type;

  // Analog comparator flags, digitised
  typedef struct packed {
    logic rect_low;
    logic rect_high;
    logic supply_over;
    logic out_low;
    logic out_over;
    logic out_below_2v5;
    logic out_above_2v8;
    logic ocl_active;
    logic tsd_hot;
    logic tsd_cool;
    logic ext_hot;
    logic rectified_voltage_outside;
    logic ext_low;
    logic ext_high;
  } wrfs_flags_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] header;
    logic [7:0] payload;
    logic [7:0] checksum;
  } wrfs_packet_type;

  typedef struct packed {
    logic [7:0] header;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] checksum;
  } wrfs_config_type;

endpackage : wrfs_pkg

// *** design/wrfs_supervisor.sv ***
// Fault supervisor, rectifier mode control and packet content of a wireless power receiver
`timescale 1ns/1ps
`include "wrfs_defines.svh"
// Behaviour
// RULE_01 - Configuration packet carries zero class/prop/count, power 0Ah, window 04h/01h.
// RULE_02 - Control error packets use header 03h with one control error byte.
// RULE_03 - Received power packets use header 04h, payload is compensated power.
// RULE_04 - End packets use header 02h with the chosen reason code.
// RULE_05 - Output low 3.5 s turns regulator off, reason 00h.
// RULE_06 - Disable pin, enable bit clear or standby timeout send reason 01h.
// RULE_07 - Current limit held 4 ms ends transfer with reason 05h.
// RULE_08 - Regulator off above 150C, back on below 130C.
// RULE_09 - Over-temperature held 200 ms keeps regulator off, reason 03h.
// RULE_10 - External thermistor hot 1 ms turns regulator off, reason 03h.
// RULE_11 - Output over 5.6 V for 64 ms turns regulator off, reason 06h.
// RULE_12 - Rectified voltage outside window for supervision time gives reason 08h.
// RULE_13 - Reason codes 02h, 04h and 07h are never sent.
// RULE_14 - Shutdown mode holds every rectifier transistor off.
// RULE_15 - Startup mode switches only the high-side transistors.
// RULE_16 - Output mode goes synchronous at 250 mA, back at 220 mA.
// RULE_17 - Lockout below 3.8 V, release above 4.0 V; regulator off, status released.
// RULE_18 - Supply over 15 V latches overvoltage: regulator off, clamp on, all stop.
// RULE_19 - External sense low: switch off, clamp off, regulator on, protocol allowed.
// RULE_20 - External sense in range: switch on low, clamp on, regulator off, stop.
// RULE_21 - External sense high: switch off at sense level, clamp on, all stop.
// RULE_22 - Overvoltage latch clears only through lockout.
// RULE_23 - Current limit 0.35 A below 2.5 V, 1.3 A above 2.8 V.
// RULE_24 - Packet checksum is XOR of header and message bytes.
// RULE_25 - Debounce timers restart at zero when their fault clears.
// RULE_26 - One end packet per shutdown, reason of first expired timer.

module wrfs_supervisor #(
  parameter int UV_CYCLES    = `WRFS_UV_CYCLES,
  parameter int OCL_CYCLES   = `WRFS_OCL_CYCLES,
  parameter int TSD_CYCLES   = `WRFS_TSD_CYCLES,
  parameter int OTP_CYCLES   = `WRFS_OTP_CYCLES,
  parameter int OV_CYCLES    = `WRFS_OV_CYCLES,
  parameter int RECTIFIED_VOLTAGE_CYCLES = `WRFS_RECTIFIED_VOLTAGE_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire wrfs_pkg::wrfs_flags_type flags,
  input  wire logic [11:0]              output_current_ma,
  input  wire wrfs_pkg::wrfs_phase_type phase,
  input  wire logic                     regulator_disable_pin,
  input  wire logic                     regulator_enable_bit,
  input  wire logic                     standby_timeout,
  input  wire logic                     ctrl_err_req,
  input  wire logic [7:0]               ctrl_err_value,
  input  wire logic                     rx_power_req,
  input  wire logic [7:0]               rx_power_value,
  output logic                          regulator_on,
  output logic                          rectifier_voltage_clamp,
  output logic                          external_switch_drive_low,
  output logic                          external_switch_follow_sense,
  output logic                          status_pin_oe,
  output logic                          protocol_enable,
  output logic                          high_side_enable,
  output logic                          low_side_enable,
  output wrfs_pkg::wrfs_rect_type       rect_mode,
  output logic [11:0]                   output_current_limit_ma,
  output logic                          lockout,
  output logic                          rectifier_overvoltage_detect,
  output logic                          shutdown_latched,
  output wrfs_pkg::wrfs_packet_type     packet,
  output wrfs_pkg::wrfs_config_type     config_packet
);

  // ==========================================================================
  // Lockout and overvoltage latch
  // ==========================================================================
  logic next_lockout;
  always_comb begin
    next_lockout = lockout;
    if (flags.rect_low) begin
      next_lockout = 1'b1; // RULE_17
    end else if (flags.rect_high) begin
      next_lockout = 1'b0; // RULE_17
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lockout <= 1'b1;
    end else begin
      lockout <= next_lockout;
    end
  end

  // Only lockout clears the latch
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rectifier_overvoltage_detect <= 1'b0;
    end else if (next_lockout) begin
      rectifier_overvoltage_detect <= 1'b0; // RULE_22
    end else if (flags.supply_over) begin
      rectifier_overvoltage_detect <= 1'b1; // RULE_18
    end
  end

  // ==========================================================================
  // Debounce timers: uv, ocl, tsd, otp, ov, rectified_voltage
  // ==========================================================================
  localparam int NTIMER = 6;
  logic [NTIMER-1:0] fault_cond;
  logic [NTIMER-1:0] expired;
  int                limit [NTIMER];

  assign fault_cond = {flags.rectified_voltage_outside, flags.out_over, flags.ext_hot,
                       flags.tsd_hot, flags.ocl_active, flags.out_low};
  assign limit[0] = UV_CYCLES;    // RULE_05
  assign limit[1] = OCL_CYCLES;   // RULE_07
  assign limit[2] = TSD_CYCLES;   // RULE_09
  assign limit[3] = OTP_CYCLES;   // RULE_10
  assign limit[4] = OV_CYCLES;    // RULE_11
  assign limit[5] = RECTIFIED_VOLTAGE_CYCLES; // RULE_12

  generate
    for (genvar i = 0; i < NTIMER; i++) begin : g_timer
      logic [31:0] count;
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          count <= 32'h0;
        end else if (!fault_cond[i] || lockout) begin
          count <= 32'h0; // RULE_25
        end else if (count < 32'(limit[i])) begin
          count <= count + 32'h1;
        end
      end
      assign expired[i] = (count >= 32'(limit[i]) - 32'h1) && fault_cond[i];
    end
  endgenerate

  // ==========================================================================
  // Internal thermal shutdown hysteresis
  // ==========================================================================
  logic thermal_off;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      thermal_off <= 1'b0;
    end else if (flags.tsd_hot) begin
      thermal_off <= 1'b1; // RULE_08
    end else if (flags.tsd_cool) begin
      thermal_off <= 1'b0; // RULE_08
    end
  end

  // ==========================================================================
  // Shutdown reason selection
  // ==========================================================================
  logic       user_off;
  logic       any_event;
  logic       protocol_ok;
  logic [7:0] reason;
  assign user_off  = regulator_disable_pin || !regulator_enable_bit;
  assign any_event = (|expired) || user_off || standby_timeout;

  // Fixed priority only breaks ties among events in the same cycle; any expired timer wins over the 01h sources
  always_comb begin
    reason = `WRFS_EPT_COMPLETE; // RULE_06
    if (expired[0]) begin
      reason = `WRFS_EPT_UNKNOWN; // RULE_05
    end else if (expired[1]) begin
      reason = `WRFS_EPT_OVER_CURRENT; // RULE_07
    end else if (expired[2] || expired[3]) begin
      reason = `WRFS_EPT_OVER_TEMP; // RULE_09 RULE_10
    end else if (expired[4]) begin
      reason = `WRFS_EPT_BATTERY_FAIL; // RULE_11
    end else if (expired[5]) begin
      reason = `WRFS_EPT_NO_RESPONSE; // RULE_12
    end
  end

  // Once latched, later expiries are ignored until lockout restarts the receiver
  logic [7:0] latched_reason;
  logic       ept_pending;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shutdown_latched <= 1'b0;
      latched_reason   <= `WRFS_EPT_UNKNOWN;
      ept_pending      <= 1'b0;
    end else if (lockout) begin
      shutdown_latched <= 1'b0;
      ept_pending      <= 1'b0;
    end else if (!shutdown_latched && any_event && !rectifier_overvoltage_detect) begin
      shutdown_latched <= 1'b1; // RULE_26
      latched_reason   <= reason; // RULE_13
      ept_pending      <= 1'b1;
    end else if (ept_pending && protocol_ok) begin
      ept_pending      <= 1'b0;
    end
  end

  // ==========================================================================
  // External supply selection
  // ==========================================================================
  logic ext_mid;
  logic ext_over;
  assign ext_mid     = flags.ext_low && !flags.ext_high;
  assign ext_over    = flags.ext_high;
  assign protocol_ok = !lockout && !rectifier_overvoltage_detect && !ext_mid && !ext_over;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      external_switch_drive_low    <= 1'b0;
      external_switch_follow_sense <= 1'b0;
      rectifier_voltage_clamp      <= 1'b0;
      protocol_enable              <= 1'b0;
      status_pin_oe                <= 1'b0;
    end else begin
      external_switch_drive_low    <= ext_mid;  // RULE_19 RULE_20
      external_switch_follow_sense <= ext_over; // RULE_21
      rectifier_voltage_clamp      <= ext_mid || ext_over || rectifier_overvoltage_detect; // RULE_18
      protocol_enable              <= protocol_ok; // RULE_18 RULE_20 RULE_21
      status_pin_oe                <= !lockout; // RULE_17
    end
  end

  // ==========================================================================
  // Regulator enable
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regulator_on <= 1'b0;
    end else begin
      regulator_on <= !lockout && !rectifier_overvoltage_detect && !ext_mid && !ext_over
                      && !thermal_off && !shutdown_latched && !any_event; // RULE_19
    end
  end

  // ==========================================================================
  // Current limit step
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      output_current_limit_ma <= `WRFS_OCL_HIGH_MA;
    end else if (flags.out_below_2v5) begin
      output_current_limit_ma <= `WRFS_OCL_LOW_MA; // RULE_23
    end else if (flags.out_above_2v8) begin
      output_current_limit_ma <= `WRFS_OCL_HIGH_MA; // RULE_23
    end
  end

  // ==========================================================================
  // Rectifier mode
  // ==========================================================================
  wrfs_pkg::wrfs_rect_type next_rect;
  always_comb begin
    next_rect = rect_mode;
    case (phase)
      wrfs_pkg::WRFS_PH_SHUTDOWN: next_rect = wrfs_pkg::WRFS_RECT_BRIDGE; // RULE_14
      wrfs_pkg::WRFS_PH_STARTUP:  next_rect = wrfs_pkg::WRFS_RECT_DIODE;  // RULE_15
      wrfs_pkg::WRFS_PH_OUTPUT: begin
        if (output_current_ma >= `WRFS_IOUT_SYNC_MA) begin
          next_rect = wrfs_pkg::WRFS_RECT_SYNC; // RULE_16
        end else if (output_current_ma <= `WRFS_IOUT_DIODE_MA) begin
          next_rect = wrfs_pkg::WRFS_RECT_DIODE; // RULE_16
        end else if (rect_mode == wrfs_pkg::WRFS_RECT_BRIDGE) begin
          next_rect = wrfs_pkg::WRFS_RECT_DIODE;
        end
      end
      default: next_rect = wrfs_pkg::WRFS_RECT_BRIDGE;
    endcase
    if (lockout) begin
      next_rect = wrfs_pkg::WRFS_RECT_BRIDGE;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rect_mode        <= wrfs_pkg::WRFS_RECT_BRIDGE;
      high_side_enable <= 1'b0;
      low_side_enable  <= 1'b0;
    end else begin
      rect_mode        <= next_rect;
      high_side_enable <= (next_rect != wrfs_pkg::WRFS_RECT_BRIDGE); // RULE_14 RULE_15
      low_side_enable  <= (next_rect == wrfs_pkg::WRFS_RECT_SYNC);   // RULE_16
    end
  end

  // ==========================================================================
  // Packet content
  // ==========================================================================
  // End packet has priority; request strobes arriving meanwhile are dropped
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      packet <= '0;
    end else begin
      packet.valid <= 1'b0;
      if (protocol_ok && ept_pending) begin
        packet.valid    <= 1'b1;
        packet.header   <= `WRFS_HDR_EPT; // RULE_04
        packet.payload  <= latched_reason;
        packet.checksum <= `WRFS_HDR_EPT ^ latched_reason; // RULE_24
      end else if (protocol_ok && !shutdown_latched && ctrl_err_req) begin
        packet.valid    <= 1'b1;
        packet.header   <= `WRFS_HDR_CTRL_ERR; // RULE_02
        packet.payload  <= ctrl_err_value;
        packet.checksum <= `WRFS_HDR_CTRL_ERR ^ ctrl_err_value; // RULE_24
      end else if (protocol_ok && !shutdown_latched && rx_power_req) begin
        packet.valid    <= 1'b1;
        packet.header   <= `WRFS_HDR_RX_POWER; // RULE_03
        packet.payload  <= rx_power_value;
        packet.checksum <= `WRFS_HDR_RX_POWER ^ rx_power_value; // RULE_24
      end
    end
  end

  logic [7:0] cfg_b0;
  logic [7:0] cfg_b2;
  logic [7:0] cfg_b3;
  assign cfg_b0 = {`WRFS_CFG_POWER_CLASS, `WRFS_CFG_MAX_POWER}; // RULE_01
  assign cfg_b2 = {`WRFS_CFG_PROP, 3'h0, `WRFS_CFG_COUNT};       // RULE_01
  assign cfg_b3 = {`WRFS_CFG_WIN_SIZE, `WRFS_CFG_WIN_OFFSET};    // RULE_01

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      config_packet <= '0;
    end else begin
      config_packet.header   <= `WRFS_HDR_CONFIG;
      config_packet.b0       <= cfg_b0;
      config_packet.b1       <= 8'h00;
      config_packet.b2       <= cfg_b2;
      config_packet.b3       <= cfg_b3;
      config_packet.b4       <= 8'h00;
      config_packet.checksum <= `WRFS_HDR_CONFIG ^ cfg_b0 ^ cfg_b2 ^ cfg_b3; // RULE_24
    end
  end

endmodule : wrfs_supervisor

// *** tb/wrfs_supervisor_properties.sv ***
// Port-level assertions of the fault supervisor
`timescale 1ns/1ps
module wrfs_supervisor_properties (
  input wire logic                      clk_sys,
  input wire logic                      reset,
  input wire wrfs_pkg::wrfs_flags_type  flags,
  input wire logic [11:0]               output_current_ma,
  input wire wrfs_pkg::wrfs_phase_type  phase,
  input wire logic                      regulator_on,
  input wire logic                      rectifier_voltage_clamp,
  input wire logic                      external_switch_drive_low,
  input wire logic                      status_pin_oe,
  input wire logic                      protocol_enable,
  input wire logic                      high_side_enable,
  input wire logic                      low_side_enable,
  input wire wrfs_pkg::wrfs_rect_type   rect_mode,
  input wire logic [11:0]               output_current_limit_ma,
  input wire logic                      lockout,
  input wire logic                      rectifier_overvoltage_detect,
  input wire wrfs_pkg::wrfs_packet_type packet
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_PKT_SUM: assert property (packet.valid |->
    packet.checksum == (packet.header ^ packet.payload)) else $error("bad checksum");
  AST_PKT_HDR: assert property (packet.valid |->
    packet.header inside {8'h02, 8'h03, 8'h04}) else $error("bad header");
  AST_NO_RSV: assert property (packet.valid && packet.header == 8'h02 |->
    !(packet.payload inside {8'h02, 8'h04, 8'h07})) else $error("reserved reason");
  AST_SHUT_MODE: assert property (phase == wrfs_pkg::WRFS_PH_SHUTDOWN |=>
    !high_side_enable && !low_side_enable) else $error("shutdown mode");
  AST_START_MODE: assert property (phase == wrfs_pkg::WRFS_PH_STARTUP |=>
    !low_side_enable) else $error("startup mode");
  AST_SYNC_MODE: assert property (phase == wrfs_pkg::WRFS_PH_OUTPUT && !lockout &&
    !flags.rect_low && !rectifier_overvoltage_detect && output_current_ma >= 12'h0fa
    |=> rect_mode == wrfs_pkg::WRFS_RECT_SYNC) else $error("sync mode");
  AST_LOCK_OFF: assert property (lockout && $past(lockout) |->
    !regulator_on && !status_pin_oe) else $error("lockout");
  AST_OV_STOP: assert property (rectifier_overvoltage_detect &&
    $past(rectifier_overvoltage_detect) |-> !regulator_on && rectifier_voltage_clamp &&
    !protocol_enable) else $error("overvoltage stop");
  AST_OV_SILENT: assert property (rectifier_overvoltage_detect &&
    $past(rectifier_overvoltage_detect) |-> !packet.valid) else $error("overvoltage packet");
  AST_OV_CLEAR: assert property ($fell(rectifier_overvoltage_detect) |->
    lockout) else $error("overvoltage clear");
  AST_EXT_MID: assert property (flags.ext_low && !flags.ext_high |=>
    external_switch_drive_low && rectifier_voltage_clamp && !regulator_on &&
    !protocol_enable) else $error("external mid");
  AST_LIMIT_LOW: assert property (flags.out_below_2v5 |=>
    output_current_limit_ma == 12'h15e) else $error("current limit");
endmodule : wrfs_supervisor_properties

bind wrfs_supervisor wrfs_supervisor_properties i_props (
  .clk_sys(clk_sys), .reset(reset), .flags(flags), .output_current_ma(output_current_ma),
  .phase(phase), .regulator_on(regulator_on), .rectifier_voltage_clamp(rectifier_voltage_clamp),
  .external_switch_drive_low(external_switch_drive_low), .status_pin_oe(status_pin_oe),
  .protocol_enable(protocol_enable), .high_side_enable(high_side_enable),
  .low_side_enable(low_side_enable), .rect_mode(rect_mode),
  .output_current_limit_ma(output_current_limit_ma), .lockout(lockout),
  .rectifier_overvoltage_detect(rectifier_overvoltage_detect), .packet(packet));

// *** tb/wrfs_tx_model.sv ***
// Transmitter side model: takes each packet and judges its framing
`timescale 1ns/1ps
module wrfs_tx_model (
  input wire logic                      clk_sys,
  input wire wrfs_pkg::wrfs_packet_type packet,
  output int                            pkt_count,
  output int                            bad_count
);
  initial begin
    pkt_count = 0;
    bad_count = 0;
  end
  // Counts packets and flags bad framing
  always @(posedge clk_sys) begin
    if (packet.valid === 1'b1) begin
      pkt_count <= pkt_count + 1;
      if (packet.checksum !== (packet.header ^ packet.payload) ||
          (packet.header === 8'h02 && packet.payload inside {8'h02, 8'h04, 8'h07})) begin
        bad_count <= bad_count + 1;
      end
    end
  end
endmodule : wrfs_tx_model

// *** tb/wrfs_supervisor_test.sv ***
// Self-checking bench of the receiver fault supervisor
`timescale 1ns/1ps
module wrfs_supervisor_test;
  logic                      clk_sys, reset, dis, en, stby, ce_req, rp_req;
  wrfs_pkg::wrfs_flags_type  flags;
  wrfs_pkg::wrfs_phase_type  phase;
  logic [11:0]               cur, limit;
  logic [7:0]                ce_val, rp_val;
  logic                      reg_on, clamp, sw_low, sw_follow, stat_oe, prot, hs, ls, lockout, ovd, sd;
  wrfs_pkg::wrfs_rect_type   rect_mode;
  wrfs_pkg::wrfs_packet_type packet;
  wrfs_pkg::wrfs_config_type cfg;
  int                        pkt_count, bad_count, err_total, n_compared;

  wrfs_supervisor #(.UV_CYCLES(8), .OCL_CYCLES(6), .TSD_CYCLES(10),
    .OV_CYCLES(7), .RECTIFIED_VOLTAGE_CYCLES(12)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .flags(flags), .output_current_ma(cur), .phase(phase),
    .regulator_disable_pin(dis), .regulator_enable_bit(en), .standby_timeout(stby),
    .ctrl_err_req(ce_req), .ctrl_err_value(ce_val), .rx_power_req(rp_req),
    .rx_power_value(rp_val), .regulator_on(reg_on), .rectifier_voltage_clamp(clamp),
    .external_switch_drive_low(sw_low), .external_switch_follow_sense(sw_follow),
    .status_pin_oe(stat_oe), .protocol_enable(prot), .high_side_enable(hs),
    .low_side_enable(ls), .rect_mode(rect_mode), .output_current_limit_ma(limit),
    .lockout(lockout), .rectifier_overvoltage_detect(ovd), .shutdown_latched(sd),
    .packet(packet), .config_packet(cfg));
  wrfs_tx_model i_tx (.clk_sys(clk_sys), .packet(packet), .pkt_count(pkt_count),
    .bad_count(bad_count));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_pkt(input logic [7:0] hdr, input logic [7:0] pl, input int bound);
    for (int i = 0; i < bound && packet.valid !== 1'b1; i++) tick(1);
    if (packet.valid !== 1'b1) begin
      err_total++;
      $display("unexpected packet: expected %h, seen none", hdr);
      test_done();
    end else begin
      chk("header", hdr, packet.header);
      chk("payload", pl, packet.payload);
    end
  endtask : wait_pkt

  // Lockout is the only way out of a latched shutdown
  task automatic recover();
    flags.rect_high = 1'b0;
    flags.rect_low = 1'b1;
    tick(2);
    chk("lockout", 1, lockout);
    chk("status_pin_oe", 0, stat_oe);
    flags.rect_low = 1'b0;
    flags.rect_high = 1'b1;
    tick(3);
  endtask : recover

  // ==========================================================
  // Scenarios
  task automatic sc_packets();
    ce_req = 1'b1;
    ce_val = 8'h5a;
    tick(1);
    wait_pkt(8'h03, 8'h5a, 1);
    chk("checksum", 8'h59, packet.checksum);
    ce_req = 1'b0;
    rp_req = 1'b1;
    rp_val = 8'hc3;
    tick(1);
    wait_pkt(8'h04, 8'hc3, 1);
    chk("checksum", 8'hc7, packet.checksum);
    rp_req = 1'b0;
    tick(2);
  endtask : sc_packets

  task automatic sc_timers();
    int         idx[6]  = '{10, 6, 5, 3, 9, 2};
    int         len[6]  = '{8, 6, 10, 25000, 7, 12};
    logic [7:0] code[6] = '{8'h00, 8'h05, 8'h03, 8'h03, 8'h06, 8'h08};
    int         c;
    for (int k = 0; k < 6; k++) begin
      flags[idx[k]] = 1'b1;
      flags.tsd_cool = (idx[k] != 5);
      tick(len[k] - 1);
      flags[idx[k]] = 1'b0;
      tick(1);
      flags[idx[k]] = 1'b1;
      tick(len[k] - 1);
      chk("shutdown_latched", 0, sd);
      wait_pkt(8'h02, code[k], 6);
      c = pkt_count;
      flags[idx[k]] = 1'b0;
      flags.tsd_cool = 1'b1;
      tick(4);
      chk("regulator_on", 0, reg_on);
      chk("packet count", c + 1, pkt_count);
      recover();
    end
  endtask : sc_timers

  task automatic sc_off_sources();
    for (int s = 0; s < 3; s++) begin
      dis = (s == 0);
      en = (s != 1);
      stby = (s == 2);
      wait_pkt(8'h02, 8'h01, 6);
      dis = 1'b0;
      en = 1'b1;
      stby = 1'b0;
      tick(1);
      chk("regulator_on", 0, reg_on);
      recover();
    end
  endtask : sc_off_sources

  task automatic sc_thermal();
    chk("regulator_on", 1, reg_on);
    flags.tsd_hot = 1'b1;
    flags.tsd_cool = 1'b0;
    tick(2);
    chk("regulator_on", 0, reg_on);
    flags.tsd_hot = 1'b0;
    flags.tsd_cool = 1'b1;
    tick(2);
    chk("regulator_on", 1, reg_on);
  endtask : sc_thermal

  task automatic sc_rect();
    logic [2:0]  ph[6]  = '{3'd0, 3'd1, 3'd2, 3'd2, 3'd2, 3'd2};
    logic [11:0] ma[6]  = '{12'h12c, 12'h12c, 12'h0f9, 12'h0fa, 12'h0dd, 12'h0dc};
    logic [1:0]  exp[6] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd1};
    for (int k = 0; k < 6; k++) begin
      phase = wrfs_pkg::wrfs_phase_type'(ph[k][1:0]);
      cur = ma[k];
      tick(2);
      chk("rect_mode", exp[k], rect_mode);
      chk("low_side_enable", exp[k] == 2'd2, ls);
      chk("high_side_enable", exp[k] != 2'd0, hs);
    end
  endtask : sc_rect

  task automatic sc_ext();
    flags.ext_low = 1'b1;
    tick(2);
    chk("switch low", 1, {sw_low, clamp, reg_on, prot} == 4'b1100);
    flags.ext_high = 1'b1;
    tick(2);
    chk("switch high", 1, {sw_low, sw_follow, clamp, reg_on, prot} == 5'b01100);
    flags.ext_low = 1'b0;
    flags.ext_high = 1'b0;
    tick(2);
    chk("switch idle", 1, {sw_low, sw_follow, clamp, reg_on, prot} == 5'b00011);
  endtask : sc_ext

  task automatic sc_ov();
    int c;
    flags.supply_over = 1'b1;
    tick(2);
    flags.supply_over = 1'b0;
    tick(1);
    chk("overvoltage", 4'b1100, {ovd, clamp, reg_on, prot});
    c = pkt_count;
    ce_req = 1'b1;
    tick(1);
    ce_req = 1'b0;
    tick(4);
    chk("packet count", c, pkt_count);
    chk("overvoltage held", 1, ovd);
    recover();
    chk("overvoltage cleared", 0, ovd);
  endtask : sc_ov

  task automatic sc_limit();
    flags.out_above_2v8 = 1'b0;
    flags.out_below_2v5 = 1'b1;
    tick(2);
    chk("limit", 12'h15e, limit);
    flags.out_below_2v5 = 1'b0;
    tick(2);
    chk("limit", 12'h15e, limit);
    flags.out_above_2v8 = 1'b1;
    tick(2);
    chk("limit", 12'h514, limit);
  endtask : sc_limit

  initial begin
    err_total = 0;
    n_compared = 0;
    reset = 1'b1;
    flags = '0;
    flags.rect_high = 1'b1;
    flags.tsd_cool = 1'b1;
    flags.out_above_2v8 = 1'b1;
    {cur, dis, stby, ce_req, rp_req, ce_val, rp_val} = '0;
    en = 1'b1;
    phase = wrfs_pkg::WRFS_PH_OUTPUT;
    tick(3);
    chk("reset state", 1, {lockout, reg_on, limit, rect_mode} == {2'b10, 12'h514, 2'b00});
    reset = 1'b0;
    tick(3);
    chk("lockout", 0, lockout);
    chk("config", 32'h0021007a, cfg[31:0]);
    chk("config", 32'h00510a00, {8'h00, cfg[55:32]});
    sc_packets();
    sc_thermal();
    sc_timers();
    sc_off_sources();
    sc_rect();
    sc_ext();
    sc_ov();
    sc_limit();
    chk("bad packets", 0, bad_count);
    test_done();
  end
endmodule : wrfs_supervisor_test
